// file: include/pmc_defs.svh
// Summary of operation
// [R1] State 00 normal, 01 wake-frame, 10 energy
// [R2] Host never writes reserved state 11
// [R3] State bits 13-12, reset 00, clear on wake
// [R4] Byte-test write wakes from low power
// [R5] Host writes only byte-test while not ready
// [R6] Writes ignored until first read after wake
// [R7] Control register readable in every state
// [R8] PHY reset bit 10 holds 100us, self-clears
// [R9] PHY reset writes ignored while bit high
// [R10] Wake-on-LAN enable bit 9 flags events
// [R11] Energy-detect enable bit 8 flags events
// [R12] Bit 6 picks open-drain or push-pull
// [R13] Cause field: none, energy, frame, multiple
// [R14] Cause bits 5-4 write-one-clear when ready
// [R15] Cause clears only with its source cleared
// [R16] Pulse mode gives 50ms, else static level
// [R17] Polarity bit sets push-pull active level
// [R18] Output enable gates only the pin
// [R19] Ready bit 0 set after stabilising
// [R20] Event inputs synchronised and latched
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMC_ADDR_W          8
`define PMC_OFF_CTRL        8'h84
`define PMC_OFF_BYTE_TEST   8'h64

// ----------------------------------------
// Field positions in the control register
// ----------------------------------------
`define PMC_BIT_STATE_HI    13
`define PMC_BIT_STATE_LO    12
`define PMC_BIT_PHY_SOFT_RESET     10
`define PMC_BIT_WAKE_ON_LAN_ENABLE      9
`define PMC_BIT_ENERGY_DETECT_ENABLE       8
`define PMC_BIT_BUF_TYPE    6
`define PMC_BIT_CAUSE_HI    5
`define PMC_BIT_CAUSE_LO    4
`define PMC_BIT_PULSE       3
`define PMC_BIT_POL         2
`define PMC_BIT_OUT_EN      1
`define PMC_BIT_READY       0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMC_RST_STATE       2'h0
`define PMC_RST_CAUSE       2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMC_CLK_PS          8000
`define PMC_PHY_SOFT_RESET_US      100
`define PMC_PULSE_MS        50
`define PMC_READY_CYC       16
// Least time: round up to whole cycles
`define PMC_PHY_SOFT_RESET_CYC \
    ((`PMC_PHY_SOFT_RESET_US * 1000000 + `PMC_CLK_PS - 1) / `PMC_CLK_PS)
// Pulse length: round down
`define PMC_PULSE_CYC \
    ((`PMC_PULSE_MS * 64'd1000000000) / `PMC_CLK_PS)

`endif

// file: include/pmc_pkg.sv
package pmc_pkg;

    // ----------------------------------------
    // Power states
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        PMC_NORMAL = 2'h0,
        PMC_WAKE   = 2'h1,
        PMC_ENERGY = 2'h2,
        PMC_RSVD   = 2'h3
    } pmc_state_type;

    // Counter width shared by all timers
    localparam int PMC_CNT_W = 24;
    typedef logic [PMC_CNT_W-1:0] pmc_cnt_type;

    // ----------------------------------------
    // Whole state of the controller
    // ----------------------------------------
    typedef struct packed
    {
        pmc_state_type state;
        logic          read_seen;
        logic          ready;
        pmc_cnt_type   ready_cnt;
        logic          phy_soft_reset;
        pmc_cnt_type   phy_cnt;
        logic          wake_on_lan_enable;
        logic          energy_detect_enable;
        logic          buf_type;
        logic [1:0]    cause;
        logic          pulse_mode;
        logic          pol;
        logic          out_en;
        pmc_cnt_type   pulse_cnt;
        logic [31:0]   rdata;
        logic          pin_out;
        logic          pin_oe;
        logic          irq;
    } pmc_regs_type;

endpackage

// file: hw/pmc_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage level synchroniser, per bit
// ----------------------------------------
module pmc_sync
#(
    parameter int WIDTH = 2
)
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // Asynchronous levels in
    input  wire logic [WIDTH-1:0] async_in,
    // Synchronised levels out
    output logic      [WIDTH-1:0] sync_out
);

    generate
        // Each bit gets its own pair of stages
        for (genvar i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_r;
            logic sync_r;
            // First stage feeds only the second
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end
                else
                begin
                    meta_r <= async_in[i];
                    sync_r <= meta_r;
                end
            end
            assign sync_out[i] = sync_r;
        end
    endgenerate

endmodule

// file: hw/pmc_power_ctrl.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_power_ctrl
#(
    parameter int PHY_SOFT_RESET_CYC = `PMC_PHY_SOFT_RESET_CYC,
    parameter int PULSE_CYC   = int'(`PMC_PULSE_CYC),
    parameter int READY_CYC   = `PMC_READY_CYC
)
(
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   arst_n,
    // Register port
    input  wire logic [`PMC_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    // Wake event sources, asynchronous levels
    input  wire logic                   wake_frame_evt,
    input  wire logic                   energy_evt,
    // Device-side status
    output pmc_pkg::pmc_state_type      power_state_select,
    output logic                        phy_reset_out,
    output logic                        wake_irq_flag,
    // Wake event pin
    output logic                        wake_event_out_o,
    output logic                        wake_event_out_oe
);
    import pmc_pkg::*;

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    // Timers are PMC_CNT_W bits wide
    initial
    begin
        if (PHY_SOFT_RESET_CYC < 1 || PHY_SOFT_RESET_CYC >= (1 << PMC_CNT_W))
            $error("PHY_SOFT_RESET_CYC out of range");
        if (PULSE_CYC < 1 || PULSE_CYC >= (1 << PMC_CNT_W))
            $error("PULSE_CYC out of range");
        if (READY_CYC < 1 || READY_CYC >= (1 << PMC_CNT_W))
            $error("READY_CYC out of range");
    end

    // Timer loads at counter width
    localparam pmc_cnt_type PHY_LOAD   = PMC_CNT_W'(PHY_SOFT_RESET_CYC);
    localparam pmc_cnt_type PULSE_LOAD = PMC_CNT_W'(PULSE_CYC);
    localparam pmc_cnt_type READY_LOAD = PMC_CNT_W'(READY_CYC);

    // ----------------------------------------
    // Event synchronisers
    // ----------------------------------------
    logic [1:0] evt_sync;     // [1] frame, [0] energy
    logic       frame_lvl;    // Synchronised wake frame level
    logic       energy_lvl;   // Synchronised energy level

    // Pin levels cross in two stages before use
    pmc_sync #(.WIDTH(2)) u_sync
    (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .async_in ({wake_frame_evt, energy_evt}),
        .sync_out (evt_sync)
    );                                                   // [R20]

    assign frame_lvl  = evt_sync[1];
    assign energy_lvl = evt_sync[0];

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    pmc_regs_type regs_r;     // Current state
    pmc_regs_type regs_nxt;   // Next state

    // Decoded accesses
    logic        hit_ctrl;    // Address hits control register
    logic        hit_test;    // Address hits byte-test register
    logic        wr_ok;       // Write allowed to take effect
    logic        frame_hit;   // Enabled wake frame event
    logic        energy_hit;  // Enabled energy event
    logic        wake_now;    // Leave low power this cycle
    logic [1:0]  cause_set;   // Cause bits set this cycle
    logic [1:0]  cause_clr;   // Cause bits cleared this cycle
    logic        low_power;   // In a reduced power state
    logic        active;      // Pin should show active
    logic [31:0] rd_word;     // Assembled control word

    assign hit_ctrl = (reg_addr == `PMC_OFF_CTRL);
    assign hit_test = (reg_addr == `PMC_OFF_BYTE_TEST);

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb
    begin
        regs_nxt  = regs_r;
        low_power = (regs_r.state != PMC_NORMAL);

        // No control write counts before the first read
        wr_ok = reg_wr && regs_r.read_seen;                  // [R6]

        // Events only count when their enable is set
        frame_hit  = frame_lvl  && regs_r.wake_on_lan_enable;            // [R10]
        energy_hit = energy_lvl && regs_r.energy_detect_enable;             // [R11]

        // Any write to byte-test wakes, read or not
        wake_now = low_power && reg_wr && hit_test;          // [R4]
        // Enabled events in a low-power state wake too
        if (low_power && (frame_hit || energy_hit))
            wake_now = 1'b1;

        // ------------------------------------
        // Read tracking
        // ------------------------------------
        // Any read arms the write path
        if (reg_rd)
            regs_nxt.read_seen = 1'b1;                        // [R6]

        // ------------------------------------
        // Ready timer
        // ------------------------------------
        if (!regs_r.ready)
        begin
            // Still settling; count down then declare ready
            if (regs_r.ready_cnt <= PMC_CNT_W'(1))
                regs_nxt.ready = !low_power;                  // [R19]
            else
                regs_nxt.ready_cnt = regs_r.ready_cnt - 1'b1;
        end

        // ------------------------------------
        // PHY reset timer
        // ------------------------------------
        if (regs_r.phy_soft_reset)
        begin
            // Held for the full minimum, then self-clears
            if (regs_r.phy_cnt <= PMC_CNT_W'(1))
                regs_nxt.phy_soft_reset = 1'b0;                      // [R8]
            else
                regs_nxt.phy_cnt = regs_r.phy_cnt - 1'b1;
        end

        // ------------------------------------
        // Control register writes
        // ------------------------------------
        cause_clr = 2'b00;
        if (wr_ok && hit_ctrl && regs_r.ready)
        begin
            // Enables and pin options
            regs_nxt.wake_on_lan_enable     = reg_wdata[`PMC_BIT_WAKE_ON_LAN_ENABLE];
            regs_nxt.energy_detect_enable      = reg_wdata[`PMC_BIT_ENERGY_DETECT_ENABLE];
            regs_nxt.buf_type   = reg_wdata[`PMC_BIT_BUF_TYPE];
            regs_nxt.pulse_mode = reg_wdata[`PMC_BIT_PULSE];
            regs_nxt.pol        = reg_wdata[`PMC_BIT_POL];
            regs_nxt.out_en     = reg_wdata[`PMC_BIT_OUT_EN];

            // PHY reset starts only while idle
            if (reg_wdata[`PMC_BIT_PHY_SOFT_RESET] && !regs_r.phy_soft_reset)  // [R9]
            begin
                regs_nxt.phy_soft_reset = 1'b1;                      // [R8]
                regs_nxt.phy_cnt = PHY_LOAD;
            end

            // Cause clears only in normal state with ready
            if (!low_power)
                cause_clr = reg_wdata[`PMC_BIT_CAUSE_HI:
                                      `PMC_BIT_CAUSE_LO];      // [R14]

            // Enter a low-power state; reserved code dropped
            unique case (pmc_state_type'(
                         reg_wdata[`PMC_BIT_STATE_HI:
                                   `PMC_BIT_STATE_LO]))
                PMC_WAKE, PMC_ENERGY:
                begin
                    regs_nxt.state = pmc_state_type'(
                        reg_wdata[`PMC_BIT_STATE_HI:
                                  `PMC_BIT_STATE_LO]);        // [R1]
                    // Not ready again until woken and settled
                    regs_nxt.ready = 1'b0;
                end
                PMC_NORMAL:
                    regs_nxt.state = regs_r.state;
                PMC_RSVD:
                    regs_nxt.state = regs_r.state;            // [R2]
            endcase
        end

        // ------------------------------------
        // Wake-up: state self-clears
        // ------------------------------------
        if (wake_now)
        begin
            regs_nxt.state     = PMC_NORMAL;                  // [R3]
            regs_nxt.read_seen = 1'b0;                        // [R6]
            regs_nxt.ready     = 1'b0;
            regs_nxt.ready_cnt = READY_LOAD;                  // [R19]
        end

        // ------------------------------------
        // Wake cause latch
        // ------------------------------------
        // Bit 0 energy, bit 1 frame; both give 11
        cause_set = {frame_hit, energy_hit};                 // [R13]
        // A clear needs its source gone; a set wins
        cause_clr = cause_clr & ~{frame_lvl, energy_lvl};    // [R15]
        regs_nxt.cause = (regs_r.cause & ~cause_clr)
                       | cause_set;                          // [R20]

        // Internal flag ignores the output enable
        regs_nxt.irq = |regs_nxt.cause;                      // [R18]

        // ------------------------------------
        // Pulse timer for the event pin
        // ------------------------------------
        // A fresh event restarts the pulse window
        if (|(cause_set & ~regs_r.cause))
            regs_nxt.pulse_cnt = PULSE_LOAD;                  // [R16]
        else if (regs_r.pulse_cnt != '0)
            regs_nxt.pulse_cnt = regs_r.pulse_cnt - 1'b1;

        // ------------------------------------
        // Event pin drive
        // ------------------------------------
        // Clearing cause or enable drops the pin
        if (regs_nxt.pulse_mode)
            active = regs_nxt.irq && (regs_nxt.pulse_cnt != '0);
        else
            active = regs_nxt.irq;                           // [R16]
        active = active && regs_nxt.out_en;                  // [R18]

        if (regs_nxt.buf_type)
        begin
            // Push-pull: always driven, polarity applies
            regs_nxt.pin_oe  = 1'b1;                         // [R12]
            regs_nxt.pin_out = regs_nxt.pol ? active
                                            : !active;       // [R17]
        end
        else
        begin
            // Open-drain: pull low only, polarity ignored
            regs_nxt.pin_oe  = active;                       // [R12]
            regs_nxt.pin_out = 1'b0;
        end

        // ------------------------------------
        // Read data
        // ------------------------------------
        // Readable in every power state
        rd_word = 32'h0000_0000;
        rd_word[`PMC_BIT_STATE_HI:`PMC_BIT_STATE_LO] = regs_r.state;
        rd_word[`PMC_BIT_PHY_SOFT_RESET]  = regs_r.phy_soft_reset;
        rd_word[`PMC_BIT_WAKE_ON_LAN_ENABLE]   = regs_r.wake_on_lan_enable;
        rd_word[`PMC_BIT_ENERGY_DETECT_ENABLE]    = regs_r.energy_detect_enable;
        rd_word[`PMC_BIT_BUF_TYPE] = regs_r.buf_type;
        rd_word[`PMC_BIT_CAUSE_HI:`PMC_BIT_CAUSE_LO] = regs_r.cause;
        rd_word[`PMC_BIT_PULSE]    = regs_r.pulse_mode;
        rd_word[`PMC_BIT_POL]      = regs_r.pol;
        rd_word[`PMC_BIT_OUT_EN]   = regs_r.out_en;
        rd_word[`PMC_BIT_READY]    = regs_r.ready;           // [R19]

        // Data stands one cycle after the strobe only
        if (reg_rd && hit_ctrl)
            regs_nxt.rdata = rd_word;                        // [R7]
        else
            regs_nxt.rdata = 32'h0000_0000;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Reset starts settling so ready rises later
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            regs_r            <= '0;
            regs_r.state      <= pmc_state_type'(`PMC_RST_STATE);
            regs_r.cause      <= `PMC_RST_CAUSE;
            regs_r.ready_cnt  <= READY_LOAD;
            regs_r.pin_out    <= 1'b0;
            regs_r.pin_oe     <= 1'b0;
        end
        else
        begin
            regs_r <= regs_nxt;
        end
    end

    // ----------------------------------------
    // Outputs, all from flops
    // ----------------------------------------
    assign reg_rdata          = regs_r.rdata;
    assign power_state_select = regs_r.state;
    assign phy_reset_out      = regs_r.phy_soft_reset;
    assign wake_irq_flag      = regs_r.irq;
    assign wake_event_out_o   = regs_r.pin_out;
    assign wake_event_out_oe  = regs_r.pin_oe;

endmodule

// file: sim/pmc_power_ctrl_assertions.sv
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_power_ctrl_assertions
#(
    parameter int PHY_SOFT_RESET_CYC = 20
)
(
    // Clock and reset
    input wire logic                   clk_sys,
    input wire logic                   arst_n,
    // Register port
    input wire logic [`PMC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata,
    // Events and status
    input wire logic                   wake_frame_evt,
    input wire logic                   energy_evt,
    input wire pmc_pkg::pmc_state_type power_state_select,
    input wire logic                   phy_reset_out,
    input wire logic                   wake_irq_flag,
    input wire logic                   wake_event_out_o,
    input wire logic                   wake_event_out_oe
);
    import pmc_pkg::*;
    // Cycles the PHY reset has been high so far
    logic [7:0] phy_cnt_r;
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
            phy_cnt_r <= 8'h00;
        else if (phy_reset_out)
            phy_cnt_r <= phy_cnt_r + 8'h01;
        else
            phy_cnt_r <= 8'h00;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside a read answer");
    a_rdata_state: assert property (
        $past(reg_rd) && $past(reg_addr) == `PMC_OFF_CTRL
        && $stable(power_state_select)
        |-> reg_rdata[13:12] == power_state_select)
        else $error("state field differs from state port");
    a_rdata_cause: assert property (
        $past(reg_rd) && $past(reg_addr) == `PMC_OFF_CTRL
        && $stable(wake_irq_flag)
        |-> (reg_rdata[5:4] != 2'b00) == wake_irq_flag)
        else $error("cause field differs from wake flag");
    a_ready_low: assert property (
        $past(reg_rd) && $past(reg_addr) == `PMC_OFF_CTRL
        && $past(power_state_select) != PMC_NORMAL
        && $past(power_state_select, 2) != PMC_NORMAL
        |-> !reg_rdata[0])
        else $error("ready read high in low power");
    // ----------------------------------------
    // Power state and PHY reset
    // ----------------------------------------
    a_state_legal: assert property (
        power_state_select != PMC_RSVD)
        else $error("reserved power state");
    a_byte_wake: assert property (
        power_state_select != PMC_NORMAL && reg_wr
        && reg_addr == `PMC_OFF_BYTE_TEST
        |-> ##[1:2] power_state_select == PMC_NORMAL)
        else $error("byte-test write did not wake");
    a_phy_start: assert property (
        $rose(phy_reset_out) |-> $past(reg_wr) && $past(reg_wdata[10])
        && $past(reg_addr) == `PMC_OFF_CTRL)
        else $error("PHY reset without a write");
    a_phy_len: assert property (
        $fell(phy_reset_out) |-> phy_cnt_r == PHY_SOFT_RESET_CYC)
        else $error("PHY reset length wrong");
    a_phy_hold: assert property (
        phy_reset_out |-> phy_cnt_r < PHY_SOFT_RESET_CYC)
        else $error("PHY reset stretched");
    // ----------------------------------------
    // Wake cause
    // ----------------------------------------
    a_irq_clear: assert property (
        $fell(wake_irq_flag) |-> $past(reg_wr)
        && $past(reg_addr) == `PMC_OFF_CTRL
        && !$past(energy_evt, 3) && !$past(wake_frame_evt, 3))
        else $error("wake flag dropped without clear");
    a_irq_cause: assert property (
        $rose(wake_irq_flag) |-> $past(energy_evt, 2)
        || $past(energy_evt, 3) || $past(wake_frame_evt, 2)
        || $past(wake_frame_evt, 3))
        else $error("wake flag without event");
    c_phy: cover property ($rose(phy_reset_out));
    c_irq: cover property ($rose(wake_irq_flag));
    c_wake: cover property (power_state_select != PMC_NORMAL
        ##1 power_state_select == PMC_NORMAL);
endmodule
bind pmc_power_ctrl pmc_power_ctrl_assertions
    #(.PHY_SOFT_RESET_CYC(PHY_SOFT_RESET_CYC)) u_chk
    (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
     .reg_rdata, .wake_frame_evt, .energy_evt, .power_state_select,
     .phy_reset_out, .wake_irq_flag, .wake_event_out_o,
     .wake_event_out_oe);

// file: sim/pmc_host_model.sv
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_host_model
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Skip host manners, for refusal tests
    input  wire logic        rude,
    // Register port
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    logic rd_done; // Read seen since reset or wake
    logic rdy;     // Last ready bit seen
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {rd_done, rdy} = 2'b00;
    end
    // Reset forgets both
    always @(negedge arst_n)
        {rd_done, rdy} = 2'b00;
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk_sys);
        d = reg_rdata;
        rd_done = 1'b1;
        if (a == `PMC_OFF_CTRL)
            rdy = d[0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        if (!rude && !rd_done)
            rd(`PMC_OFF_CTRL, t);
        if (!rude && !rdy && a != `PMC_OFF_BYTE_TEST)
            return;
        if (d[13:12] == 2'b11)
            d[13] = 1'b0;
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        // Waking means read again and wait for ready
        if (a == `PMC_OFF_BYTE_TEST)
            {rd_done, rdy} = 2'b00;
    endtask
endmodule

// file: sim/tb_pmc_power_ctrl.sv
`timescale 1ns/1ps
`include "pmc_defs.svh"
module tb_pmc_power_ctrl;
    import pmc_pkg::*;
    localparam int PHY_CYC = 20;
    localparam int PULSE_CYC = 30;
    localparam logic [7:0] CTRL = `PMC_OFF_CTRL;
    logic          clk_sys = 1'b0;
    logic          arst_n = 1'b0;
    logic          rude = 1'b0;
    logic          wake_frame_evt = 1'b0;
    logic          energy_evt = 1'b0;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata, reg_rdata, rdv;
    logic          reg_wr, reg_rd, phy_out, irq, pin_o, pin_oe;
    pmc_state_type st;
    int            n_errors = 0, n_compared = 0;
    int            phy_hi = 0, pulse_hi = 0, base;
    always #4 clk_sys = ~clk_sys;
    // High-time counters for PHY reset and active pin
    always @(negedge clk_sys)
    begin
        phy_hi += (phy_out === 1'b1);
        pulse_hi += (pin_o === 1'b1 && pin_oe === 1'b1);
    end
    pmc_host_model host (.clk_sys, .arst_n, .rude, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    pmc_power_ctrl #(.PHY_SOFT_RESET_CYC(PHY_CYC), .PULSE_CYC(PULSE_CYC)) dut
        (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
         .reg_rdata, .wake_frame_evt, .energy_evt,
         .power_state_select(st), .phy_reset_out(phy_out),
         .wake_irq_flag(irq), .wake_event_out_o(pin_o),
         .wake_event_out_oe(pin_oe));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic rdchk(input logic [31:0] exp);
        host.rd(CTRL, rdv);
        chk(rdv, exp);
    endtask
    // Drive event levels, then let the sync chain settle
    task automatic ev(input logic e, input logic f);
        @(posedge clk_sys);
        energy_evt     <= e;
        wake_frame_evt <= f;
        tick(5);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
    endtask
    // Bounded poll of the ready bit
    task automatic wait_ready();
        rdv = '0;
        for (int i = 0; i < 40 && rdv[0] !== 1'b1; i++)
            host.rd(CTRL, rdv);
        chk(rdv[0], 1'b1);
        if (rdv[0] !== 1'b1)
            give_verdict();
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        do_reset();
        rdchk(32'h0000_0000);
        ev(1'b1, 1'b0);
        chk(irq, 1'b0);
        ev(1'b0, 1'b0);
        wait_ready();
        $display("test reset done");
        // Second reset, write with no read first
        do_reset();
        rude <= 1'b1;
        tick(20);
        host.wr(CTRL, 32'h0000_0346);
        rude <= 1'b0;
        rdchk(32'h0000_0001);
        host.wr(CTRL, 32'h0000_0346);
        rdchk(32'h0000_0347);
        chk({pin_o, pin_oe}, 2'b01);
        $display("test access done");
        ev(1'b1, 1'b0);
        chk({pin_o, pin_oe, irq}, 3'b111);
        rdchk(32'h0000_0357);
        ev(1'b1, 1'b1);
        rdchk(32'h0000_0377);
        host.wr(CTRL, 32'h0000_0376);
        rdchk(32'h0000_0377);
        ev(1'b0, 1'b0);
        host.wr(CTRL, 32'h0000_0376);
        rdchk(32'h0000_0347);
        host.wr(CTRL, 32'h0000_0342);
        tick(1);
        chk({pin_o, pin_oe, irq}, 3'b110);
        $display("test events done");
        // Open-drain ignores polarity; enable gates only the pin
        host.wr(CTRL, 32'h0000_0306);
        tick(1);
        chk(pin_oe, 1'b0);
        ev(1'b1, 1'b0);
        chk({pin_o, pin_oe}, 2'b01);
        host.wr(CTRL, 32'h0000_0304);
        tick(1);
        chk({pin_oe, irq}, 2'b01);
        ev(1'b0, 1'b0);
        host.wr(CTRL, 32'h0000_0334);
        tick(1);
        chk(irq, 1'b0);
        $display("test pin done");
        host.wr(CTRL, 32'h0000_014E);
        base = pulse_hi;
        ev(1'b1, 1'b0);
        tick(60);
        chk(pulse_hi - base, PULSE_CYC);
        ev(1'b0, 1'b0);
        host.wr(CTRL, 32'h0000_017E);
        base = phy_hi;
        host.wr(CTRL, 32'h0000_0400);
        host.wr(CTRL, 32'h0000_0400);
        tick(40);
        chk(phy_hi - base, PHY_CYC);
        $display("test timers done");
        for (int s = 1; s < 3; s++)
        begin
            host.wr(CTRL, 32'(s) << 12);
            tick(1);
            chk(st, s);
            rdchk(32'(s) << 12);
            host.wr(`PMC_OFF_BYTE_TEST, 32'h0000_0000);
            tick(1);
            chk(st, PMC_NORMAL);
            wait_ready();
        end
        host.wr(CTRL, 32'h0000_2100);
        tick(1);
        chk(st, PMC_ENERGY);
        ev(1'b1, 1'b0);
        chk({st, irq}, 3'b001);
        wait_ready();
        ev(1'b0, 1'b0);
        host.wr(CTRL, 32'h0000_0010);
        rdchk(32'h0000_0001);
        $display("test power done");
        give_verdict();
    end
endmodule
